// >>> hw/dot_product_regs.svh
// field positions, encodings and reset values for the dot product unit
`ifndef DOT_PRODUCT_REGS_SVH
`define DOT_PRODUCT_REGS_SVH
`define MAJOR_HI 31
`define MAJOR_LO 26
`define MINOR_HI 5
`define MINOR_LO 0
`define SUBOP_HI 10
`define SUBOP_LO 6
`define INDEX_HI 12
`define INDEX_LO 11
`define ZERO_HI 15
`define ZERO_LO 13
`define EXTENDED_MAJOR_OPCODE 6'h1f
`define DOT_PRODUCT_MINOR_OPCODE 6'h30
`define SUBOP_UDOT_UPPER_BYTES 5'h03
`define SUBOP_UDOT_LOWER_BYTES 5'h07
`define SUBOP_CROSS_DOT_ACCUMULATE 5'h08
`define SUBOP_DOT_SUBTRACT 5'h01
`define ACC_RESET 64'h0000000000000000
`endif

// >>> hw/dot_product_pkg.sv
// types shared by the dot product unit
package dot_product_pkg;
    typedef enum logic [2:0] {
        op_none,
        op_udot_upper_bytes,
        op_udot_lower_bytes,
        op_cross_dot_accumulate,
        op_dot_subtract
    } dot_op_e;
    typedef enum logic [1:0] {
        exc_none,
        exc_reserved,
        exc_dsp_disabled
    } exc_kind_e;
endpackage

// >>> hw/dot_product_decode.sv
// instruction decoder for the dot product unit
`include "dot_product_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module dot_product_decode (
    input wire logic [31:0] instr,
    output dot_product_pkg::dot_op_e op,
    output logic [1:0] index
);
    wire logic [4:0] subop;
    wire logic family;
    assign subop = instr[`SUBOP_HI:`SUBOP_LO];
    assign index = instr[`INDEX_HI:`INDEX_LO];
    assign family = (instr[`MAJOR_HI:`MAJOR_LO] == `EXTENDED_MAJOR_OPCODE)
        && (instr[`MINOR_HI:`MINOR_LO] == `DOT_PRODUCT_MINOR_OPCODE)
        && (instr[`ZERO_HI:`ZERO_LO] == 3'h0);
    always_comb begin
        op = dot_product_pkg::op_none;
        if (family) begin
            if (subop == `SUBOP_UDOT_UPPER_BYTES) begin
                op = dot_product_pkg::op_udot_upper_bytes;
            end else if (subop == `SUBOP_UDOT_LOWER_BYTES) begin
                op = dot_product_pkg::op_udot_lower_bytes;
            end else if (subop == `SUBOP_CROSS_DOT_ACCUMULATE) begin
                op = dot_product_pkg::op_cross_dot_accumulate;
            end else if (subop == `SUBOP_DOT_SUBTRACT) begin
                op = dot_product_pkg::op_dot_subtract;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/dot_product_accumulate.sv
// dot product with accumulate datapath and four accumulator pairs
// How it works
// - decode major, minor, index and sub-operation fields
// - upper byte pairs multiplied unsigned
// - zero-extended products summed into accumulator
// - lower byte pairs multiplied, accumulated alike
// - signed cross halfword products formed
// - 33-bit cross sum sign-extended, added
// - signed straight halfword products formed
// - straight sum sign-extended, subtracted
// - index picks one of four pairs
// - saturation flags never touched
// - old low words in, halves sign-extended out
// - no operand-dependent exception raised
// - absent or disabled extension raises exception
`include "dot_product_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module dot_product_accumulate #(
    parameter int ACC_COUNT = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] operand_one,
    input wire logic [31:0] operand_two,
    input wire logic dsp_present,
    input wire logic dsp_enabled,
    input wire logic [1:0] read_index,
    output logic [63:0] top_word,
    output logic [63:0] bottom_word,
    output logic done,
    output logic exc_valid,
    output dot_product_pkg::exc_kind_e exc_kind,
    output logic flags_write
);
    logic rst_meta_b;
    logic rst_sync_b;
    logic [63:0] top_store [ACC_COUNT];
    logic [63:0] bottom_store [ACC_COUNT];
    dot_product_pkg::dot_op_e op;
    wire logic [1:0] index;
    wire logic is_upper;
    wire logic is_lower;
    wire logic is_cross;
    wire logic is_subtract;
    wire logic known_op;
    wire logic recognised;
    wire logic dsp_ready;
    wire logic accept;
    wire logic fault_absent;
    wire logic fault_disabled;
    wire logic [ACC_COUNT-1:0] pair_write;
    wire logic index_in_range;
    wire logic read_in_range;
    wire logic [7:0] one_byte3;
    wire logic [7:0] one_byte2;
    wire logic [7:0] one_byte1;
    wire logic [7:0] one_byte0;
    wire logic [7:0] two_byte3;
    wire logic [7:0] two_byte2;
    wire logic [7:0] two_byte1;
    wire logic [7:0] two_byte0;
    wire logic [15:0] one_half_hi;
    wire logic [15:0] one_half_lo;
    wire logic [15:0] two_half_hi;
    wire logic [15:0] two_half_lo;
    wire logic [15:0] prod_byte3;
    wire logic [15:0] prod_byte2;
    wire logic [15:0] prod_byte1;
    wire logic [15:0] prod_byte0;
    wire logic [63:0] upper_byte_sum;
    wire logic [63:0] lower_byte_sum;
    wire logic signed [31:0] prod_cross_hi;
    wire logic signed [31:0] prod_cross_lo;
    wire logic signed [31:0] prod_straight_hi;
    wire logic signed [31:0] prod_straight_lo;
    wire logic [32:0] cross_sum;
    wire logic [32:0] straight_sum;
    wire logic [31:0] old_top_low;
    wire logic [31:0] old_bottom_low;
    wire logic [63:0] old_acc;
    wire logic [63:0] acc_upper;
    wire logic [63:0] acc_lower;
    wire logic [63:0] acc_cross;
    wire logic [63:0] acc_subtract;
    logic [63:0] next_acc;
    wire logic [63:0] next_top;
    wire logic [63:0] next_bottom;
    wire logic next_exc_valid;
    dot_product_pkg::exc_kind_e next_exc_kind;
    wire logic [63:0] next_top_word;
    wire logic [63:0] next_bottom_word;

    function automatic logic [15:0] mul_u8(input logic [7:0] a, input logic [7:0] b);
        mul_u8 = {8'h00, a} * {8'h00, b};
    endfunction

    function automatic logic signed [31:0] mul_s16(input logic [15:0] a,
                                                   input logic [15:0] b);
        mul_s16 = $signed(a) * $signed(b);
    endfunction

    function automatic logic [63:0] sext32(input logic [31:0] v);
        sext32 = {{32{v[31]}}, v};
    endfunction

    // products keep their own sign in bit 32, so the sum cannot wrap
    function automatic logic [32:0] add_s32(input logic [31:0] a, input logic [31:0] b);
        add_s32 = {a[31], a} + {b[31], b};
    endfunction

    function automatic logic [63:0] sext33(input logic [32:0] v);
        sext33 = {{31{v[32]}}, v};
    endfunction

    function automatic logic [63:0] zext16(input logic [15:0] v);
        zext16 = {48'h0000_0000_0000, v};
    endfunction

    // an index with no pair behind it writes nothing
    function automatic logic [ACC_COUNT-1:0] pair_select(input logic [1:0] sel);
        pair_select = '0;
        for (int i = 0; i < ACC_COUNT; i++) begin
            if (sel == 2'(i)) begin
                pair_select[i] = 1'b1;
            end
        end
    endfunction

    function automatic logic pair_exists(input logic [1:0] sel);
        pair_exists = (int'(sel) < ACC_COUNT);
    endfunction

    // reset released through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    dot_product_decode decoder (
        .instr(instr),
        .op(op),
        .index(index)
    );

    // only the four decoded operations count
    assign is_upper = (op == dot_product_pkg::op_udot_upper_bytes);
    assign is_lower = (op == dot_product_pkg::op_udot_lower_bytes);
    assign is_cross = (op == dot_product_pkg::op_cross_dot_accumulate);
    assign is_subtract = (op == dot_product_pkg::op_dot_subtract);
    assign known_op = is_upper || is_lower || is_cross || is_subtract;
    assign recognised = in_valid && known_op;

    assign dsp_ready = dsp_present && dsp_enabled;
    assign fault_absent = recognised && !dsp_present;
    assign fault_disabled = recognised && dsp_present && !dsp_enabled;
    assign accept = recognised && dsp_ready;

    assign pair_write = accept ? pair_select(index) : '0;

    // lanes always multiply; only the selected result is written
    assign one_byte3 = operand_one[31:24];
    assign one_byte2 = operand_one[23:16];
    assign one_byte1 = operand_one[15:8];
    assign one_byte0 = operand_one[7:0];
    assign two_byte3 = operand_two[31:24];
    assign two_byte2 = operand_two[23:16];
    assign two_byte1 = operand_two[15:8];
    assign two_byte0 = operand_two[7:0];
    assign one_half_hi = operand_one[31:16];
    assign one_half_lo = operand_one[15:0];
    assign two_half_hi = operand_two[31:16];
    assign two_half_lo = operand_two[15:0];

    assign prod_byte3 = mul_u8(one_byte3, two_byte3);
    assign prod_byte2 = mul_u8(one_byte2, two_byte2);
    assign prod_byte1 = mul_u8(one_byte1, two_byte1);
    assign prod_byte0 = mul_u8(one_byte0, two_byte0);
    assign upper_byte_sum = zext16(prod_byte3) + zext16(prod_byte2);
    assign lower_byte_sum = zext16(prod_byte1) + zext16(prod_byte0);

    assign prod_cross_hi = mul_s16(one_half_hi, two_half_lo);
    assign prod_cross_lo = mul_s16(one_half_lo, two_half_hi);
    assign prod_straight_hi = mul_s16(one_half_hi, two_half_hi);
    assign prod_straight_lo = mul_s16(one_half_lo, two_half_lo);
    assign cross_sum = add_s32(prod_cross_hi, prod_cross_lo);
    assign straight_sum = add_s32(prod_straight_hi, prod_straight_lo);

    // only low words of old value used
    // a pair beyond ACC_COUNT reads as zero
    assign index_in_range = pair_exists(index);
    assign old_top_low = index_in_range ? top_store[index][31:0] : 32'h0000_0000;
    assign old_bottom_low = index_in_range ? bottom_store[index][31:0] : 32'h0000_0000;
    assign old_acc = {old_top_low, old_bottom_low};

    assign acc_upper = old_acc + upper_byte_sum;
    assign acc_lower = old_acc + lower_byte_sum;
    assign acc_cross = old_acc + sext33(cross_sum);
    assign acc_subtract = old_acc - sext33(straight_sum);

    // wrap-around arithmetic; no overflow trap exists
    // no data-dependent exception
    always_comb begin
        next_acc = old_acc;
        case (op)
            dot_product_pkg::op_udot_upper_bytes: begin
                next_acc = acc_upper;
            end
            dot_product_pkg::op_udot_lower_bytes: begin
                next_acc = acc_lower;
            end
            dot_product_pkg::op_cross_dot_accumulate: begin
                next_acc = acc_cross;
            end
            dot_product_pkg::op_dot_subtract: begin
                next_acc = acc_subtract;
            end
            default: begin
                next_acc = old_acc;
            end
        endcase
    end

    assign next_top = sext32(next_acc[63:32]);
    assign next_bottom = sext32(next_acc[31:0]);

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int i = 0; i < ACC_COUNT; i++) begin
                top_store[i] <= `ACC_RESET;
                bottom_store[i] <= `ACC_RESET;
            end
        end else begin
            for (int i = 0; i < ACC_COUNT; i++) begin
                if (pair_write[i]) begin
                    top_store[i] <= next_top;
                    bottom_store[i] <= next_bottom;
                end
            end
        end
    end

    assign next_exc_valid = fault_absent || fault_disabled;
    assign next_exc_kind = fault_absent ? dot_product_pkg::exc_reserved
        : fault_disabled ? dot_product_pkg::exc_dsp_disabled
        : dot_product_pkg::exc_none;

    // done and exc_valid are high for one edge per strobe cycle and never high together
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            done <= 1'b0;
            exc_valid <= 1'b0;
            exc_kind <= dot_product_pkg::exc_none;
        end else begin
            done <= accept;
            exc_valid <= next_exc_valid;
            exc_kind <= next_exc_kind;
        end
    end

    assign flags_write = 1'b0;

    // view lags the store by one edge; a new result shows two edges after its strobe
    assign read_in_range = pair_exists(read_index);
    assign next_top_word = read_in_range ? top_store[read_index] : `ACC_RESET;
    assign next_bottom_word = read_in_range ? bottom_store[read_index] : `ACC_RESET;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            top_word <= `ACC_RESET;
            bottom_word <= `ACC_RESET;
        end else begin
            top_word <= next_top_word;
            bottom_word <= next_bottom_word;
        end
    end
endmodule
`default_nettype wire

// >>> test/dot_product_asserts.sv
// assertion checker for the dot product unit
`timescale 1ns/100ps
`default_nettype none
module dot_product_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] operand_one,
    input wire logic [31:0] operand_two,
    input wire logic dsp_present,
    input wire logic dsp_enabled,
    input wire logic [1:0] read_index,
    input wire logic [63:0] top_word,
    input wire logic [63:0] bottom_word,
    input wire logic done,
    input wire logic exc_valid,
    input wire dot_product_pkg::exc_kind_e exc_kind,
    input wire logic flags_write
);
    // operands are not decoded here, only the instruction word
    wire logic rec = in_valid && instr[31:26] == 6'h1f && instr[5:0] == 6'h30
        && instr[15:13] == 3'h0 && (instr[10:6] inside {5'h03, 5'h07, 5'h08, 5'h01});
    wire logic ok = dsp_present && dsp_enabled;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_dn; rec && ok |=> done; endproperty
    a_dn: assert property (p_dn) else $error("done missing");
    property p_dc; done |-> $past(rec && ok); endproperty
    a_dc: assert property (p_dc) else $error("done without cause");
    property p_rs; rec && !dsp_present |=> exc_valid && exc_kind == dot_product_pkg::exc_reserved;
    endproperty
    a_rs: assert property (p_rs) else $error("reserved fault missing");
    property p_ds; rec && dsp_present && !dsp_enabled
        |=> exc_valid && exc_kind == dot_product_pkg::exc_dsp_disabled; endproperty
    a_ds: assert property (p_ds) else $error("disabled fault missing");
    property p_nx; rec && ok |=> !exc_valid; endproperty
    a_nx: assert property (p_nx) else $error("fault on good instruction");
    property p_fw; !flags_write; endproperty
    a_fw: assert property (p_fw) else $error("flag write seen");
    property p_sx; top_word[63:32] == {32{top_word[31]}}
        && bottom_word[63:32] == {32{bottom_word[31]}}; endproperty
    a_sx: assert property (p_sx) else $error("half not sign extended");
    property p_st; !done && $stable(read_index) |=> $stable(top_word) && $stable(bottom_word);
    endproperty
    a_st: assert property (p_st) else $error("pair changed without update");
endmodule
bind dot_product_accumulate dot_product_asserts chk (.clk, .rst_b, .in_valid, .instr,
    .operand_one, .operand_two, .dsp_present, .dsp_enabled, .read_index, .top_word,
    .bottom_word, .done, .exc_valid, .exc_kind, .flags_write);
`default_nettype wire

// >>> test/pipeline_model.sv
// pipeline model presenting one instruction per strobe cycle
`timescale 1ns/100ps
`default_nettype none
module pipeline_model (
    input wire logic clk,
    input wire logic issue,
    input wire logic [31:0] word,
    input wire logic [31:0] src_a,
    input wire logic [31:0] src_b,
    output logic in_valid,
    output logic [31:0] instr,
    output logic [31:0] operand_one,
    output logic [31:0] operand_two
);
    initial {in_valid, instr, operand_one, operand_two} = '0;
    always @(negedge clk) begin
        in_valid <= issue;
        // idle lines toggle so a stale word never looks held
        instr <= issue ? word : ~instr;
        operand_one <= issue ? src_a : ~operand_one;
        operand_two <= issue ? src_b : ~operand_two;
    end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the dot product unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 0, rst_b = 0, issue = 0, dsp_present = 1, dsp_enabled = 1;
    logic [31:0] word = 0, src_a = 0, src_b = 0, instr, operand_one, operand_two;
    logic [1:0] read_index = 0;
    logic in_valid, done, exc_valid, flags_write;
    logic [63:0] top_word, bottom_word;
    dot_product_pkg::exc_kind_e exc_kind;
    logic [63:0] acc [4] = '{default: 0};
    int mismatches = 0, tests_run = 0, cycles = 0;
    pipeline_model pipe (.clk, .issue, .word, .src_a, .src_b, .in_valid, .instr,
        .operand_one, .operand_two);
    dot_product_accumulate uut (.clk, .rst_b, .in_valid, .instr, .operand_one, .operand_two,
        .dsp_present, .dsp_enabled, .read_index, .top_word, .bottom_word, .done, .exc_valid,
        .exc_kind, .flags_write);
    initial forever #5 clk = ~clk;
    task check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic run_op(input logic [4:0] sub, input logic [1:0] idx, input logic [31:0] a,
        input logic [31:0] b, input int reps, input logic bad);
        logic ok;
        logic signed [63:0] d;
        case (sub)
            5'h03: d = a[31:24] * b[31:24] + a[23:16] * b[23:16];
            5'h07: d = a[15:8] * b[15:8] + a[7:0] * b[7:0];
            5'h08: d = $signed(a[31:16]) * $signed(b[15:0])
                + $signed(a[15:0]) * $signed(b[31:16]);
            default: d = -($signed(a[31:16]) * $signed(b[31:16])
                + $signed(a[15:0]) * $signed(b[15:0]));
        endcase
        @(negedge clk);
        ok = dsp_present && dsp_enabled && !bad;
        issue <= 1;
        word <= {6'h1f, 10'h0, 2'h0, bad, idx, sub, 6'h30};
        src_a <= a;
        src_b <= b;
        read_index <= idx;
        repeat (reps) @(negedge clk);
        issue <= 0;
        @(posedge clk);
        #1;
        check(done, ok);
        check(exc_valid, !bad && !ok);
        if (!ok && !bad) check(exc_kind, dsp_present ? dot_product_pkg::exc_dsp_disabled
            : dot_product_pkg::exc_reserved);
        if (ok) repeat (reps) acc[idx] = acc[idx] + d;
        repeat (reps) @(posedge clk);
        #1;
        check(top_word, {{32{acc[idx][63]}}, acc[idx][63:32]});
        check(bottom_word, {{32{acc[idx][31]}}, acc[idx][31:0]});
    endtask
    task t_upper; run_op(5'h03, 2'h0, 32'hff80_1234, 32'hff02_5678, 2, 1'h0); endtask
    task t_lower; run_op(5'h07, 2'h1, 32'h1234_ff80, 32'h5678_ff02, 1, 1'h0); endtask
    task t_cross; run_op(5'h08, 2'h2, 32'h8000_8000, 32'h8000_8000, 2, 1'h0); endtask
    task t_sub; run_op(5'h01, 2'h3, 32'h7fff_8000, 32'h7fff_8000, 1, 1'h0); endtask
    task t_fault;
        @(negedge clk) dsp_present <= 0;
        run_op(5'h03, 2'h1, 32'hffff_ffff, 32'hffff_ffff, 1, 1'h0);
        @(negedge clk) {dsp_present, dsp_enabled} <= 2'h2;
        run_op(5'h08, 2'h1, 32'h7fff_7fff, 32'h7fff_7fff, 1, 1'h0);
        @(negedge clk) dsp_enabled <= 1;
        run_op(5'h07, 2'h1, 32'hffff_ffff, 32'hffff_ffff, 1, 1'h1);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst_b <= 1;
        repeat (3) @(posedge clk);
        t_upper();
        t_lower();
        t_cross();
        t_sub();
        t_fault();
        complete_run();
    end
endmodule
`default_nettype wire
